// ==== design/spsr_map.vh ====
// register offsets, field positions, reset values and widths of the serial port status block
// Operation
// - spi master: sample late or mid by setting
// - i2c: sample setting controls slew rate
// - spi: clock edge setting picks launch edge
// - i2c: clock edge setting selects smbus thresholds
// - data/address flag shows last byte kind
// - stop flag: stop seen last, else cleared
// - start flag: start seen last, else cleared
// - read/write flag captures direction on match
// - slave shows direction, master shows transmit busy
// - nor of read/write flag and enables means idle
// - ten-bit: flag requests slave address reload
// - receive: buffer full once byte complete
// - i2c transmit: full until data bits shifted out
// - all bits reset to zero, two writable
`ifndef SPSR_MAP_VH
`define SPSR_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define SPSR_ADDR_W 4
`define SPSR_OFF_STATUS 4'h0
`define SPSR_OFF_CTRL 4'h1
`define SPSR_OFF_SLAVE_ADDR 4'h2
`define SPSR_OFF_DATA_BUF 4'h3
`define SPSR_OFF_SEQ_CTRL 4'h4

// ****************************************
// status field positions
// ****************************************
`define SPSR_ST_SAMPLE 7
`define SPSR_ST_EDGE 6
`define SPSR_ST_DATA_ADDR 5
`define SPSR_ST_STOP 4
`define SPSR_ST_START 3
`define SPSR_ST_RW 2
`define SPSR_ST_UA 1
`define SPSR_ST_BF 0

// ****************************************
// control field positions
// ****************************************
`define SPSR_CT_ENABLE 0
`define SPSR_CT_I2C 1
`define SPSR_CT_MASTER 2
`define SPSR_CT_TEN_BIT 3
`define SPSR_SEQ_W 5

// ****************************************
// reset values and constants
// ****************************************
`define SPSR_RST_BYTE 8'h00
`define SPSR_RST_SEQ 5'h00
`define SPSR_BITS_PER_BYTE 4'h8
`define SPSR_CNT_ZERO 4'h0
`define SPSR_CNT_ONE 4'h1
`define SPSR_TEN_BIT_HDR 5'h1e

`endif

// ==== design/spsr_pin_sync.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module spsr_pin_sync #(
  parameter IDLE_LEVEL = 1'b1 // level shown until the pin settles
) (
  input wire clk,
  input wire reset,
  input wire pin_in,
  output reg pin_out
);

  reg stage1_reg; // metastability catcher, read by stage2 only
  reg stage2_reg; // first settled copy
  reg stage3_reg; // second settled copy

  // ****************************************
  // shift chain and filter
  // ****************************************
  // a change counts only once stages two and three agree
  always @(posedge clk) begin
    if (reset) begin
      stage1_reg <= IDLE_LEVEL;
      stage2_reg <= IDLE_LEVEL;
      stage3_reg <= IDLE_LEVEL;
      pin_out <= IDLE_LEVEL;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg) begin
        pin_out <= stage3_reg;
      end
    end
  end

endmodule // spsr_pin_sync

// ==== design/spsr_status_reg.v ====
// serial port status register with bus monitor for i2c and spi
`timescale 1ns/10ps
`include "spsr_map.vh"
module spsr_status_reg (
  input wire clk,
  input wire reset,
  input wire [`SPSR_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire scl_in, // i2c clock or spi clock pin
  input wire sda_in, // i2c data or spi data-in pin
  output reg sample_late, // spi master samples at end of bit
  output reg slew_ctrl_en, // i2c slew-rate control on
  output reg tx_on_idle_edge, // spi launches on active-to-idle edge
  output reg smbus_thresh_en, // i2c smbus input thresholds
  output reg port_idle // read/write flag clear and no sequence pending
);

  // ****************************************
  // functions
  // ****************************************
  // 7-bit address compare against the address register
  function addr7_match;
    input [7:0] rx;
    input [7:0] own;
    begin
      addr7_match = (rx[7:1] == own[7:1]);
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  wire scl_f; // filtered clock pin
  wire sda_f; // filtered data pin
  reg scl_prev_reg; // clock level one cycle ago
  reg sda_prev_reg; // data level one cycle ago
  reg [1:0] setting_reg; // sample point and clock edge bits
  reg [7:0] ctrl_reg; // enable, mode, master, ten-bit
  reg [`SPSR_SEQ_W-1:0] seq_reg; // start, restart, stop, receive, ack enables
  reg [7:0] slave_addr_reg; // own address
  reg [7:0] data_buf_reg; // received or outgoing byte
  reg [7:0] shift_reg; // bits assembling on the bus
  reg [3:0] bit_cnt_reg; // bits of current byte
  reg data_addr_reg; // last byte was data
  reg stop_seen_reg; // stop detected last
  reg start_seen_reg; // start detected last
  reg dir_reg; // direction of last matched address
  reg ua_reg; // address register needs reload
  reg bf_reg; // buffer full
  reg tx_active_reg; // a byte is being shifted out
  reg first_byte_reg; // next byte is an address byte
  reg low_addr_reg; // ten-bit low address byte expected
  reg [7:0] rdata_next; // read mux
  wire enabled; // port switched on
  wire i2c_mode; // i2c rather than spi
  wire master_mode; // master rather than slave
  wire scl_rise; // clock rising edge
  wire scl_fall; // clock falling edge
  wire start_det; // data falls with clock high
  wire stop_det; // data rises with clock high
  wire spi_edge; // spi sampling edge
  wire bit_edge; // edge that takes one bit in
  wire byte_done; // eighth bit taken
  wire [7:0] byte_now; // completed byte
  wire rw_shown; // flag shown in the status read
  wire [7:0] status_now; // assembled status byte
  wire wr_status; // status write strobe
  wire wr_buf; // data buffer write strobe
  wire rd_buf; // data buffer read strobe
  wire wr_addr; // slave address write strobe

  // ****************************************
  // pin synchronisers
  // ****************************************
  spsr_pin_sync #(.IDLE_LEVEL(1'b1)) u_scl_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(scl_in),
    .pin_out(scl_f)
  );

  spsr_pin_sync #(.IDLE_LEVEL(1'b1)) u_sda_sync (
    .clk(clk),
    .reset(reset),
    .pin_in(sda_in),
    .pin_out(sda_f)
  );

  // ****************************************
  // edge and condition detection
  // ****************************************
  assign enabled = ctrl_reg[`SPSR_CT_ENABLE];
  assign i2c_mode = ctrl_reg[`SPSR_CT_I2C];
  assign master_mode = ctrl_reg[`SPSR_CT_MASTER];
  assign scl_rise = scl_f & ~scl_prev_reg;
  assign scl_fall = ~scl_f & scl_prev_reg;
  assign start_det = i2c_mode & scl_f & scl_prev_reg & sda_prev_reg & ~sda_f;
  assign stop_det = i2c_mode & scl_f & scl_prev_reg & ~sda_prev_reg & sda_f;
  // idle-low clock assumed: launch on fall means sample on rise
  assign spi_edge = setting_reg[0] ? scl_rise : scl_fall;
  assign bit_edge = enabled & (i2c_mode ? scl_rise : spi_edge);
  // the ninth i2c clock carries the acknowledge, not a data bit
  assign byte_done = bit_edge & (bit_cnt_reg == (`SPSR_BITS_PER_BYTE - `SPSR_CNT_ONE));
  assign byte_now = {shift_reg[6:0], sda_f};

  // ****************************************
  // bus strobes
  // ****************************************
  assign wr_status = wr & (addr == `SPSR_OFF_STATUS);
  assign wr_buf = wr & (addr == `SPSR_OFF_DATA_BUF);
  assign rd_buf = rd & (addr == `SPSR_OFF_DATA_BUF);
  assign wr_addr = wr & (addr == `SPSR_OFF_SLAVE_ADDR);

  // ****************************************
  // software settings
  // ****************************************
  // only the two upper bits take a write; the flags belong to hardware
  always @(posedge clk) begin
    if (reset) begin
      setting_reg <= 2'h0;
      ctrl_reg <= `SPSR_RST_BYTE;
      seq_reg <= `SPSR_RST_SEQ;
      slave_addr_reg <= `SPSR_RST_BYTE;
    end else begin
      if (wr_status) begin
        setting_reg <= wdata[`SPSR_ST_SAMPLE:`SPSR_ST_EDGE];
      end
      if (wr & (addr == `SPSR_OFF_CTRL)) begin
        ctrl_reg <= wdata;
      end
      // sequence enables drop when the port is switched off
      if (wr & (addr == `SPSR_OFF_SEQ_CTRL)) begin
        seq_reg <= wdata[`SPSR_SEQ_W-1:0];
      end else if (!enabled) begin
        seq_reg <= `SPSR_RST_SEQ;
      end
      if (wr_addr) begin
        slave_addr_reg <= wdata;
      end
    end
  end

  // ****************************************
  // bus monitor and status flags
  // ****************************************
  // every hardware set is placed after the software clear so it wins
  always @(posedge clk) begin
    if (reset) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      shift_reg <= `SPSR_RST_BYTE;
      bit_cnt_reg <= `SPSR_CNT_ZERO;
      data_buf_reg <= `SPSR_RST_BYTE;
      data_addr_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      dir_reg <= 1'b0;
      ua_reg <= 1'b0;
      bf_reg <= 1'b0;
      tx_active_reg <= 1'b0;
      first_byte_reg <= 1'b0;
      low_addr_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
      // software side: buffer load or drain, address reload
      if (rd_buf & ~tx_active_reg) begin
        bf_reg <= 1'b0;
      end
      if (wr_buf) begin
        data_buf_reg <= wdata;
        bf_reg <= 1'b1;
        tx_active_reg <= 1'b1;
        shift_reg <= wdata;
      end
      if (wr_addr) begin
        ua_reg <= 1'b0;
      end
      if (!enabled) begin
        // switched off: conditions forgotten, byte framing restarts
        stop_seen_reg <= 1'b0;
        start_seen_reg <= 1'b0;
        bit_cnt_reg <= `SPSR_CNT_ZERO;
        tx_active_reg <= 1'b0;
      end else if (start_det) begin
        start_seen_reg <= 1'b1;
        stop_seen_reg <= 1'b0;
        bit_cnt_reg <= `SPSR_CNT_ZERO;
        first_byte_reg <= 1'b1;
        low_addr_reg <= 1'b0;
      end else if (stop_det) begin
        stop_seen_reg <= 1'b1;
        start_seen_reg <= 1'b0;
        bit_cnt_reg <= `SPSR_CNT_ZERO;
        first_byte_reg <= 1'b0;
        tx_active_reg <= 1'b0;
      end else if (i2c_mode & scl_rise & (bit_cnt_reg == `SPSR_BITS_PER_BYTE)) begin
        // acknowledge clock: framing restarts for the next byte
        bit_cnt_reg <= `SPSR_CNT_ZERO;
      end else if (bit_edge) begin
        shift_reg <= byte_now;
        bit_cnt_reg <= bit_cnt_reg + `SPSR_CNT_ONE;
        if (byte_done) begin
          if (!i2c_mode) begin
            data_buf_reg <= byte_now;
            bf_reg <= 1'b1;
            tx_active_reg <= 1'b0;
            bit_cnt_reg <= `SPSR_CNT_ZERO;
          end else if (tx_active_reg) begin
            // data bits out: empty without waiting for ack or stop
            bf_reg <= 1'b0;
            tx_active_reg <= 1'b0;
            data_addr_reg <= 1'b1;
          end else if (first_byte_reg | low_addr_reg) begin
            data_addr_reg <= 1'b0;
            data_buf_reg <= byte_now;
            bf_reg <= 1'b1;
            first_byte_reg <= 1'b0;
            low_addr_reg <= 1'b0;
            if (ctrl_reg[`SPSR_CT_TEN_BIT]) begin
              if (low_addr_reg & (byte_now == slave_addr_reg)) begin
                ua_reg <= 1'b1;
              end else if (first_byte_reg & (byte_now[7:3] == `SPSR_TEN_BIT_HDR) &
                           (byte_now[2:1] == slave_addr_reg[2:1])) begin
                ua_reg <= 1'b1;
                dir_reg <= byte_now[0];
                low_addr_reg <= ~byte_now[0];
              end
            end else if (addr7_match(byte_now, slave_addr_reg)) begin
              dir_reg <= byte_now[0];
            end
          end else begin
            data_addr_reg <= 1'b1;
            data_buf_reg <= byte_now;
            bf_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // status assembly and read port
  // ****************************************
  // master shows transmit busy, slave shows captured direction
  assign rw_shown = master_mode ? tx_active_reg : dir_reg;
  assign status_now = {setting_reg, data_addr_reg, stop_seen_reg, start_seen_reg,
                       rw_shown, ua_reg, bf_reg};

  // read mux; unmapped offsets read as zero
  always @* begin
    rdata_next = `SPSR_RST_BYTE;
    case (addr)
      `SPSR_OFF_STATUS: begin
        rdata_next = status_now;
      end
      `SPSR_OFF_CTRL: begin
        rdata_next = ctrl_reg;
      end
      `SPSR_OFF_SLAVE_ADDR: begin
        rdata_next = slave_addr_reg;
      end
      `SPSR_OFF_DATA_BUF: begin
        rdata_next = data_buf_reg;
      end
      `SPSR_OFF_SEQ_CTRL: begin
        rdata_next = {3'h0, seq_reg};
      end
      default: begin
        rdata_next = `SPSR_RST_BYTE;
      end
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (reset) begin
      rdata <= `SPSR_RST_BYTE;
      sample_late <= 1'b0;
      slew_ctrl_en <= 1'b1;
      tx_on_idle_edge <= 1'b0;
      smbus_thresh_en <= 1'b0;
      port_idle <= 1'b1;
    end else begin
      rdata <= rd ? rdata_next : `SPSR_RST_BYTE;
      // late sampling only as spi master; slave held at zero by the master gate
      sample_late <= ~i2c_mode & master_mode & setting_reg[1];
      slew_ctrl_en <= ~(i2c_mode & setting_reg[1]);
      tx_on_idle_edge <= ~i2c_mode & setting_reg[0];
      smbus_thresh_en <= i2c_mode & setting_reg[0];
      port_idle <= ~(rw_shown | (|seq_reg));
    end
  end

endmodule // spsr_status_reg

// ==== test/spsr_checker.sv ====
// assertion checker for the serial port status register
`timescale 1ns/10ps
`include "spsr_map.vh"
module spsr_checker (
  input wire clk,
  input wire reset,
  input wire [`SPSR_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire sample_late,
  input wire slew_ctrl_en,
  input wire tx_on_idle_edge,
  input wire smbus_thresh_en,
  input wire port_idle
);
  // ****************************************
  // shadow of the software settings
  // ****************************************
  reg [7:0] ctl_reg; // mirrored control byte
  reg [1:0] set_reg; // mirrored status bits 7:6
  wire i2c = ctl_reg[`SPSR_CT_I2C]; // mode bit
  wire e_smp = !i2c && ctl_reg[`SPSR_CT_MASTER] && set_reg[1]; // late sample
  wire e_slew = !(i2c && set_reg[1]); // slew control on
  wire e_txe = !i2c && set_reg[0]; // spi launch edge
  wire e_smb = i2c && set_reg[0]; // smbus thresholds
  // mirror only what the bus writes; flags are never shadowed
  always @(posedge clk) begin
    if (reset) begin
      ctl_reg <= 8'h00;
      set_reg <= 2'h0;
    end else if (wr && addr == `SPSR_OFF_CTRL) begin
      ctl_reg <= wdata;
    end else if (wr && addr == `SPSR_OFF_STATUS) begin
      set_reg <= wdata[7:6];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************
  // properties
  // ****************************************
  property p_rst_vals;
    disable iff (1'b0) reset |=> rdata == 8'h00 && port_idle && slew_ctrl_en && !sample_late;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_smp;
    sample_late == $past(e_smp);
  endproperty
  a_smp: assert property (p_smp) else $error("sample point output wrong");
  property p_slew;
    slew_ctrl_en == $past(e_slew);
  endproperty
  a_slew: assert property (p_slew) else $error("slew control output wrong");
  property p_txe;
    tx_on_idle_edge == $past(e_txe);
  endproperty
  a_txe: assert property (p_txe) else $error("launch edge output wrong");
  property p_smb;
    smbus_thresh_en == $past(e_smb);
  endproperty
  a_smb: assert property (p_smb) else $error("smbus threshold output wrong");
  property p_stat_rd;
    rd && addr == `SPSR_OFF_STATUS |=> rdata[7:6] == $past(set_reg);
  endproperty
  a_stat_rd: assert property (p_stat_rd) else $error("status settings read wrong");
  property p_unmap;
    rd && addr > `SPSR_OFF_SEQ_CTRL |=> rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_busy;
    wr && addr == `SPSR_OFF_SEQ_CTRL && wdata[4:0] != 5'h00 && ctl_reg[0] |=> ##1 !port_idle;
  endproperty
  a_busy: assert property (p_busy) else $error("idle with sequence pending");
endmodule // spsr_checker
bind spsr_status_reg spsr_checker chk (.clk(clk), .reset(reset), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sample_late(sample_late),
  .slew_ctrl_en(slew_ctrl_en), .tx_on_idle_edge(tx_on_idle_edge),
  .smbus_thresh_en(smbus_thresh_en), .port_idle(port_idle));

// ==== test/spsr_peer.sv ====
// i2c bus peer that drives the clock and data pins
`timescale 1ns/10ps
module spsr_peer (
  output reg scl,
  output reg sda
);
  localparam real HALF = 80.0; // half of the 160 ns link clock
  // both lines pulled up while idle, clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  integer k; // bit index of the byte being sent
  // lines go high first so a start also works after a byte; clock parks low
  task start_cond; begin
    sda = 1'b1;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda = 1'b0;
    #HALF;
    scl = 1'b0;
    #HALF;
  end endtask
  // eight data bits msb first, data moves only while clock low
  task send_byte(input [7:0] d); begin
    for (k = 7; k >= 0; k = k - 1) begin
      sda = d[k];
      #HALF;
      scl = 1'b1;
      #HALF;
      scl = 1'b0;
    end
    // ninth clock: line released to its pull-up, no acknowledge driven
    sda = 1'b1;
    #HALF;
    scl = 1'b1;
    #HALF;
    scl = 1'b0;
  end endtask
  // data low under low clock, clock up, then data rises while clock high
  task stop_cond; begin
    sda = 1'b0;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda = 1'b1;
    #HALF;
  end endtask
endmodule // spsr_peer

// ==== test/testbench.sv ====
// self-checking bench for the serial port status register
`timescale 1ns/10ps
`include "spsr_map.vh"
module testbench;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [`SPSR_ADDR_W-1:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_q = 1'b0; // read taken last edge
  wire [7:0] rdata;
  wire scl, sda, sample_point_sel, slew, txe, smb, idle;
  reg [15:0] exp_q[$]; // {mask, value} per read
  reg [15:0] e16;
  reg [31:0] rnd = 32'd32411; // xorshift state
  reg [7:0] st, b;
  integer n_errors = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  always #5 clk = ~clk;
  spsr_peer peer (.scl(scl), .sda(sda));
  spsr_status_reg dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scl_in(scl), .sda_in(sda), .sample_late(sample_point_sel),
    .slew_ctrl_en(slew), .tx_on_idle_edge(txe), .smbus_thresh_en(smb), .port_idle(idle));
  // ****************************************
  // helpers
  // ****************************************
  task next_rnd; begin
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  end endtask
  task wr_reg(input [`SPSR_ADDR_W-1:0] a, input [7:0] d); begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end endtask
  // the note goes in before the strobe so the watcher always finds it
  task rd_reg(input [`SPSR_ADDR_W-1:0] a, input [7:0] m, input [7:0] e); begin
    exp_q.push_back({m, e});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  end endtask
  task cmp_byte(input [7:0] m, input [7:0] e, input [7:0] g); begin
    n_compared = n_compared + 1;
    if ((g & m) !== (e & m)) begin
      n_errors = n_errors + 1;
      $display("BAD rdata exp %h got %h mask %h", e, g, m);
    end
  end endtask
  task cmp_bit(input [63:0] nm, input e, input g); begin
    n_compared = n_compared + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("BAD %0s exp %b got %b", nm, e, g);
    end
  end endtask
  // pin path is about five cycles, so eight leaves margin
  task settle; begin
    repeat (8) @(posedge clk);
  end endtask
  task summarize; begin
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end endtask
  // watcher: read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q) begin
      e16 = exp_q.pop_front();
      cmp_byte(e16[15:8], e16[7:0], rdata);
    end
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_reg(`SPSR_OFF_STATUS, 8'hff, 8'h00);
    rd_reg(4'hf, 8'hff, 8'h00);
    // sweep spi slave, spi master, i2c slave, i2c master
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(`SPSR_OFF_CTRL, {5'h00, i[0], i[1], 1'b1});
      next_rnd;
      st = rnd[7:0];
      if (i == 0) st[7] = 1'b0;
      wr_reg(`SPSR_OFF_STATUS, st);
      rd_reg(`SPSR_OFF_STATUS, 8'hff, st & 8'hc0);
      cmp_bit("smp", ~i[1] & i[0] & st[7], sample_point_sel);
      cmp_bit("slew", ~(i[1] & st[7]), slew);
      cmp_bit("txe", ~i[1] & st[6], txe);
      cmp_bit("smb", i[1] & st[6], smb);
    end
    // i2c slave receive
    wr_reg(`SPSR_OFF_CTRL, 8'h03);
    wr_reg(`SPSR_OFF_STATUS, 8'h00);
    wr_reg(`SPSR_OFF_SLAVE_ADDR, 8'ha4);
    peer.start_cond;
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'hff, 8'h08);
    peer.send_byte(8'ha5);
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h3f, 8'h0d);
    rd_reg(`SPSR_OFF_DATA_BUF, 8'hff, 8'ha5);
    rd_reg(`SPSR_OFF_STATUS, 8'h01, 8'h00);
    next_rnd;
    b = rnd[7:0];
    peer.send_byte(b);
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h21, 8'h21);
    rd_reg(`SPSR_OFF_DATA_BUF, 8'hff, b);
    peer.stop_cond;
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h18, 8'h10);
    peer.start_cond;
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h18, 8'h08);
    wr_reg(`SPSR_OFF_CTRL, 8'h02);
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h18, 8'h00);
    peer.stop_cond;
    // ten-bit slave: header with matching upper bits asks for reload
    wr_reg(`SPSR_OFF_CTRL, 8'h0b);
    peer.start_cond;
    peer.send_byte(8'hf4);
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h23, 8'h03);
    wr_reg(`SPSR_OFF_SLAVE_ADDR, 8'ha4);
    rd_reg(`SPSR_OFF_STATUS, 8'h02, 8'h00);
    peer.stop_cond;
    // i2c master transmit
    wr_reg(`SPSR_OFF_CTRL, 8'h07);
    peer.start_cond;
    settle;
    wr_reg(`SPSR_OFF_DATA_BUF, 8'h3c);
    rd_reg(`SPSR_OFF_STATUS, 8'h05, 8'h05);
    cmp_bit("idle", 1'b0, idle);
    peer.send_byte(8'h3c);
    settle;
    rd_reg(`SPSR_OFF_STATUS, 8'h05, 8'h00);
    cmp_bit("idle", 1'b1, idle);
    wr_reg(`SPSR_OFF_SEQ_CTRL, 8'h04);
    settle;
    cmp_bit("idle", 1'b0, idle);
    wr_reg(`SPSR_OFF_SEQ_CTRL, 8'h00);
    settle;
    cmp_bit("idle", 1'b1, idle);
    peer.stop_cond;
    settle;
    summarize;
  end
endmodule // testbench
